// file: src/fdbs_seq.sv
// Start-up, fault latch and overvoltage sequencer with APB registers
`timescale 1ns/1ns
`include "fdbs_consts.svh"
module fdbs_seq #(
  parameter int unsigned TICK_CYC   = `FDBS_TICK_CYC,
  parameter int unsigned STBY_TICKS = `FDBS_STBY_TICKS,
  parameter int unsigned DET_TICKS  = `FDBS_DET_TICKS
) (
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // APB slave
  input  wire logic [7:0]    paddr,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  // Comparator and strap inputs
  input  wire logic          bias_ok,
  input  wire logic          bias_lost,
  input  wire logic          uv_enable_on,
  input  wire logic          uv_enable_off,
  input  wire logic          clock_chain_output_term,
  input  wire logic          short_found,
  input  wire logic          breaker_gate_good,
  input  wire logic          hv_overvoltage_sense,
  input  wire logic          lv_overvoltage_sense,
  input  wire logic          boost_mode,
  input  wire logic          channel_one_enable,
  input  wire logic          channel_two_enable,
  // Open-drain fault flag
  input  wire logic          fault_flag_n_in,
  output logic               fault_flag_n_out,
  output logic               fault_flag_n_oe,
  // Power stage controls
  output logic               breaker_source_on,
  output logic               detect_active,
  output logic [1:0]         high_side_drive,
  output logic [1:0]         low_side_drive,
  output logic               ss_discharge,
  output logic               standby,
  output fdbs_pkg::fdbs_state_t seq_state,
  output logic               irq
);
  import fdbs_pkg::*;

  fdbs_state_t state_r;
  fdbs_state_t state_nxt;
  logic [11:0] tick_cnt_r;
  logic        tick;
  logic        det_en_r;
  logic        ctrl_drv_r;
  fdbs_ev_t    istat_r;
  fdbs_ev_t    istat_nxt;
  fdbs_ev_t    imask_r;
  fdbs_ev_t    ev;
  logic        ov_hv;
  logic        ov_lv;
  logic        ov_any;
  logic        ov_hv_q;
  logic        ov_lv_q;
  logic        ext_fault;
  logic        run;
  logic        wr_en;
  logic [31:0] rd_val;
  logic        rd_hit;
  logic        det_done;
  logic        skip_done;

  fdbs_filt_if flt_if ();
  fdbs_filt_if hv_if ();
  fdbs_filt_if lv_if ();

  // Slow time base; long intervals count its ticks
  fdbs_tick_div #(.DIV(TICK_CYC)) u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick)
  );

  // Filters on the fault flag and both overvoltage comparators
  assign flt_if.raw = fault_flag_n_in;
  assign hv_if.raw  = hv_overvoltage_sense;
  assign lv_if.raw  = lv_overvoltage_sense;

  fdbs_glitch_filt #(.CYC(`FDBS_FLTF_CYC), .RST_VAL(1'b1)) u_flt (
    .pclk    (pclk),
    .presetn (presetn),
    .f       (flt_if)
  );
  fdbs_glitch_filt #(.CYC(`FDBS_FLTOV_CYC), .RST_VAL(1'b0)) u_hv (
    .pclk    (pclk),
    .presetn (presetn),
    .f       (hv_if)
  );
  fdbs_glitch_filt #(.CYC(`FDBS_FLTOV_CYC), .RST_VAL(1'b0)) u_lv (
    .pclk    (pclk),
    .presetn (presetn),
    .f       (lv_if)
  );

  // Low-port protection is meaningless while boosting
  assign ov_hv     = hv_if.clean;                // R13 R15
  assign ov_lv     = lv_if.clean & ~boost_mode;  // R12 R14
  assign ov_any    = ov_hv | ov_lv;
  assign ext_fault = ~flt_if.clean;              // R09
  assign det_done  = tick && tick_cnt_r == 12'(DET_TICKS - 1);
  assign skip_done = tick && tick_cnt_r == 12'(STBY_TICKS - 1);

  // Sequencer next state; supply loss overrides everything
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      FDBS_IDLE:
        // Wait for the filtered flag to read released, else a stale low
        // left over from a cleared latch would fault again at once
        if (bias_ok && uv_enable_on && flt_if.clean)       // R03 R10
          state_nxt = clock_chain_output_term ? FDBS_SKIP  // R01
                                              : FDBS_DETECT;
      FDBS_DETECT:
        if (short_found)
          state_nxt = FDBS_FAULT;                          // R07
        else if (det_done)
          state_nxt = FDBS_CHARGE;                         // R04 R05
      FDBS_CHARGE:
        if (breaker_gate_good)
          state_nxt = FDBS_STANDBY;                        // R06
      FDBS_SKIP:
        if (skip_done)
          state_nxt = FDBS_STANDBY;                        // R02 R11
      FDBS_STANDBY:
        state_nxt = FDBS_STANDBY;
      FDBS_FAULT:
        state_nxt = FDBS_FAULT;                            // R10
      default:
        state_nxt = FDBS_IDLE;
    endcase
    if (state_r != FDBS_IDLE && state_r != FDBS_FAULT && ext_fault)
      state_nxt = FDBS_FAULT;                              // R08
    if (bias_lost || uv_enable_off)
      state_nxt = FDBS_IDLE;                               // R10 R17
  end

  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_r <= FDBS_IDLE;                                // R17
    else
      state_r <= state_nxt;
  end

  // Interval counter restarts on every state change
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tick_cnt_r <= 12'h000;
    else if (state_nxt != state_r)
      tick_cnt_r <= 12'h000;
    else if (tick)
      tick_cnt_r <= tick_cnt_r + 12'h001;                  // R16
  end

  // Strap is caught by the clock at leaving idle, never by reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      det_en_r <= 1'b0;
    else if (state_r == FDBS_IDLE && state_nxt != FDBS_IDLE)
      det_en_r <= !clock_chain_output_term;                // R01
  end

  // Drivers run only in standby, free of overvoltage
  assign run = state_nxt == FDBS_STANDBY && !ov_any && ctrl_drv_r;

  // Registered power stage controls
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fault_flag_n_out  <= 1'b0;
      fault_flag_n_oe   <= 1'b0;
      breaker_source_on <= 1'b0;
      detect_active     <= 1'b0;
      high_side_drive   <= 2'h0;
      low_side_drive    <= 2'h0;
      ss_discharge      <= 1'b1;
      standby           <= 1'b0;
    end
    else
    begin
      fault_flag_n_out  <= 1'b0;
      fault_flag_n_oe   <= state_nxt == FDBS_FAULT;       // R07
      breaker_source_on <= state_nxt == FDBS_CHARGE ||
                           state_nxt == FDBS_SKIP ||
                           state_nxt == FDBS_STANDBY;     // R05 R11
      detect_active     <= state_nxt == FDBS_DETECT;      // R04
      high_side_drive   <= {run & channel_two_enable,
                            run & channel_one_enable};    // R13 R14
      low_side_drive    <= {run & channel_two_enable,
                            run & channel_one_enable};
      ss_discharge      <= !run;                          // R13 R14
      standby           <= state_nxt == FDBS_STANDBY;     // R06
    end
  end

  // Edge memory of the filtered alarms for event pulses
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ov_hv_q <= 1'b0;
      ov_lv_q <= 1'b0;
    end
    else
    begin
      ov_hv_q <= ov_hv;
      ov_lv_q <= ov_lv;
    end
  end

  // Events that set sticky status bits
  always_comb
  begin
    ev = '0;
    ev[`FDBS_EV_SHORT] = state_r == FDBS_DETECT && short_found &&
                         state_nxt == FDBS_FAULT;
    ev[`FDBS_EV_EXT]   = state_r != FDBS_FAULT && !short_found &&
                         state_nxt == FDBS_FAULT;
    ev[`FDBS_EV_HV]    = ov_hv & ~ov_hv_q;
    ev[`FDBS_EV_LV]    = ov_lv & ~ov_lv_q;
    ev[`FDBS_EV_STBY]  = state_r != FDBS_STANDBY &&
                         state_nxt == FDBS_STANDBY;
  end

  // APB write strobe at the completing access edge
  assign wr_en = psel && penable && pready && pwrite;

  // Write one to clear; a new event wins over the clear
  always_comb
  begin
    istat_nxt = istat_r;
    if (wr_en && paddr == `FDBS_ISTAT_OFS)
      istat_nxt = istat_r & ~pwdata[`FDBS_NEV-1:0];
    istat_nxt = istat_nxt | ev;
  end

  // Software registers and interrupt output
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_drv_r <= `FDBS_CTRL_RST;
      imask_r    <= `FDBS_IMASK_RST;
      istat_r    <= '0;
      irq        <= 1'b0;
    end
    else
    begin
      if (wr_en && paddr == `FDBS_CTRL_OFS)
        ctrl_drv_r <= pwdata[`FDBS_CTRL_DRV];
      if (wr_en && paddr == `FDBS_IMASK_OFS)
        imask_r <= pwdata[`FDBS_NEV-1:0];
      istat_r <= istat_nxt;
      irq     <= |(istat_nxt & imask_r);
    end
  end

  // Read decode; unmapped addresses answer with an error
  always_comb
  begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    if (paddr == `FDBS_CTRL_OFS)
      rd_val[`FDBS_CTRL_DRV] = ctrl_drv_r;
    else if (paddr == `FDBS_STAT_OFS)
    begin
      rd_val[2:0]            = state_r;
      rd_val[`FDBS_ST_DETEN] = det_en_r;
      rd_val[`FDBS_ST_HVOV]  = ov_hv;
      rd_val[`FDBS_ST_LVOV]  = ov_lv;
      rd_val[`FDBS_ST_FLAG]  = flt_if.clean;
    end
    else if (paddr == `FDBS_ISTAT_OFS)
      rd_val[`FDBS_NEV-1:0] = istat_r;
    else if (paddr == `FDBS_IMASK_OFS)
      rd_val[`FDBS_NEV-1:0] = imask_r;
    else
      rd_hit = 1'b0;
  end

  // Answer prepared in setup so access completes with no wait
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      prdata  <= (psel && !penable && !pwrite) ? rd_val : 32'h0000_0000;
      pslverr <= psel && !penable && !rd_hit;
    end
  end

  assign seq_state = state_r;

  // Checks of the sequencer against its cause signals
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [17:0] det_len_r;

  // Helper: cycles spent in detection; wide enough for the full interval
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      det_len_r <= 18'h00000;
    else if (state_r == FDBS_DETECT)
      det_len_r <= det_len_r + 18'h00001;
    else
      det_len_r <= 18'h00000;
  end

  a_short_latch: assert property (
    state_r == FDBS_DETECT && short_found && !bias_lost && !uv_enable_off
    |=> state_r == FDBS_FAULT && fault_flag_n_oe && !fault_flag_n_out) // R07
    else $error("short did not latch fault");

  a_ext_fault: assert property (
    state_r == FDBS_STANDBY && ext_fault && !bias_lost && !uv_enable_off
    |=> state_r == FDBS_FAULT && !breaker_source_on) // R08
    else $error("external fault did not open breaker");

  a_latch_hold: assert property (
    state_r == FDBS_FAULT && !bias_lost && !uv_enable_off
    |=> state_r == FDBS_FAULT) // R10
    else $error("fault latch left without release");

  a_latch_clear: assert property (
    bias_lost || uv_enable_off
    |=> state_r == FDBS_IDLE && !breaker_source_on &&
        !fault_flag_n_oe && high_side_drive == 2'h0) // R17
    else $error("supply loss did not return to idle");

  a_det_length: assert property (
    state_r == FDBS_DETECT ##1 state_r == FDBS_CHARGE
    |-> $past(det_len_r) >= 18'((DET_TICKS - 1) * TICK_CYC)) // R04
    else $error("detection interval too short");

  a_skip_nogate: assert property (
    state_r == FDBS_SKIP && skip_done && !ext_fault &&
    !bias_lost && !uv_enable_off
    |=> state_r == FDBS_STANDBY && breaker_source_on) // R02 R11
    else $error("skip path did not reach standby");

  a_hv_off: assert property (
    ov_hv |=> high_side_drive == 2'h0 && low_side_drive == 2'h0 &&
              ss_discharge) // R13
    else $error("drivers on during high-port overvoltage");

  a_lv_boost: assert property (
    lv_if.clean && boost_mode && !ov_hv && state_nxt == FDBS_STANDBY &&
    ctrl_drv_r && channel_one_enable
    |=> high_side_drive[0]) // R12
    else $error("low-port alarm acted in boost");

  a_lv_off: assert property (
    ov_lv ##1 1'b1 |-> low_side_drive == 2'h0 && ss_discharge) // R14
    else $error("drivers on during low-port overvoltage");

  a_irq_level: assert property (
    ##1 irq == |($past(istat_nxt) & $past(imask_r)))
    else $error("interrupt output disagrees with status");

  c_det_standby: cover property (
    state_r == FDBS_CHARGE ##1 state_r == FDBS_STANDBY);
  c_skip_standby: cover property (
    state_r == FDBS_SKIP ##1 state_r == FDBS_STANDBY);
  c_short_fault: cover property (ev[`FDBS_EV_SHORT]);
  c_hv_restart: cover property (
    state_r == FDBS_STANDBY && $fell(ov_hv));
endmodule

// file: common/fdbs_consts.svh
// Offsets, fields, reset values and timing counts of the sequencer
// What this block does
// R01: At start-up sense the clock-chain output strap: no resistor enables detection.
// R02: Detection off: skip detection, reach standby about 300 us after supply good.
// R03: Detection on: start switch-short check only with enable and bias good.
// R04: The detection interval lasts 2 to 3 ms over all switches.
// R05: No short found: switch on the breaker gate charging source.
// R06: Breaker gate good: enter standby and wait for the channel enables.
// R07: Short found: pull the fault flag low at once, latch shutdown.
// R08: Fault flag pulled low from outside: breaker off, latch shutdown.
// R09: Fault flag low pulses under 2 us are ignored.
// R10: Fault latch clears only on enable below 1.25 V or bias below 8 V.
// R11: Breaker source stays on after start-up; no gate check when detection off.
// R12: Low-port overvoltage ignored in boost; high-port overvoltage always active.
// R13: High-port overvoltage: all drivers off, soft-start discharged, restart after.
// R14: Low-port overvoltage: all drivers off, soft-start discharged, restart after.
// R15: Both overvoltage inputs pass a 5 us glitch filter first.
// R16: Thresholds are synchronous booleans; intervals are counted clock cycles.
// R17: Reset or supply loss returns to idle, drivers and source off, flag free.
`ifndef FDBS_CONSTS_SVH
`define FDBS_CONSTS_SVH
`define FDBS_CLK_MHZ    100
`define FDBS_TICK_NS    1000
`define FDBS_TICK_CYC   ((`FDBS_TICK_NS * `FDBS_CLK_MHZ) / 1000)
`define FDBS_FLTF_NS    2000
`define FDBS_FLTF_CYC   ((`FDBS_FLTF_NS * `FDBS_CLK_MHZ + 999) / 1000)
`define FDBS_FLTOV_NS   5000
`define FDBS_FLTOV_CYC  ((`FDBS_FLTOV_NS * `FDBS_CLK_MHZ + 999) / 1000)
`define FDBS_STBY_US    300
`define FDBS_STBY_TICKS ((`FDBS_STBY_US * 1000) / `FDBS_TICK_NS)
`define FDBS_DET_US     2500
`define FDBS_DET_TICKS  ((`FDBS_DET_US * 1000) / `FDBS_TICK_NS)
`define FDBS_CTRL_OFS   8'h00
`define FDBS_STAT_OFS   8'h04
`define FDBS_ISTAT_OFS  8'h08
`define FDBS_IMASK_OFS  8'h0c
`define FDBS_CTRL_DRV   0
`define FDBS_ST_DETEN   3
`define FDBS_ST_HVOV    4
`define FDBS_ST_LVOV    5
`define FDBS_ST_FLAG    6
`define FDBS_EV_SHORT   0
`define FDBS_EV_EXT     1
`define FDBS_EV_HV      2
`define FDBS_EV_LV      3
`define FDBS_EV_STBY    4
`define FDBS_NEV        5
`define FDBS_CTRL_RST   1'b1
`define FDBS_IMASK_RST  5'h00
`endif

// file: common/fdbs_pkg.sv
// Types shared by the sequencer modules
package fdbs_pkg;
  typedef enum logic [2:0] {
    FDBS_IDLE    = 3'b000,
    FDBS_DETECT  = 3'b001,
    FDBS_CHARGE  = 3'b010,
    FDBS_SKIP    = 3'b011,
    FDBS_STANDBY = 3'b100,
    FDBS_FAULT   = 3'b101
  } fdbs_state_t;
  typedef logic [4:0] fdbs_ev_t;
endpackage

// file: common/fdbs_filt_if.sv
// Raw and filtered level of one glitch-filtered input
`timescale 1ns/1ns
interface fdbs_filt_if;
  logic raw;
  logic clean;
  modport user (output raw, input clean);
  modport filt (input raw, output clean);
endinterface

// file: src/fdbs_glitch_filt.sv
// Glitch filter: output follows input only after it stands CYC cycles
`timescale 1ns/1ns
module fdbs_glitch_filt #(
  parameter int unsigned CYC     = 2,
  parameter logic        RST_VAL = 1'b0
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Filtered signal
  fdbs_filt_if.filt f
);
  logic [9:0] cnt_r;
  logic       clean_r;

  // Count how long the input differs; shorter pulses die out
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_r   <= 10'h000;
      clean_r <= RST_VAL;
    end
    else if (f.raw == clean_r)
      cnt_r <= 10'h000;
    else if (cnt_r == 10'(CYC - 1))
    begin
      cnt_r   <= 10'h000;
      clean_r <= f.raw;
    end
    else
      cnt_r <= cnt_r + 10'h001;
  end

  assign f.clean = clean_r;

  a_filt_width: assert property (@(posedge pclk) disable iff (!presetn)
    $changed(clean_r) |-> $past(cnt_r) == 10'(CYC - 1)) // R09 R15
    else $error("filter output changed before full width");
endmodule

// file: src/fdbs_tick_div.sv
// Divider giving a one-cycle enable pulse every DIV clocks
`timescale 1ns/1ns
module fdbs_tick_div #(
  parameter int unsigned DIV = 100
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Slow enable
  output logic      tick
);
  logic [11:0] cnt_r;
  logic        tick_r;

  // Free-running divider for the slow internal time base
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_r  <= 12'h000;
      tick_r <= 1'b0;
    end
    else if (cnt_r == 12'(DIV - 1))
    begin
      cnt_r  <= 12'h000;
      tick_r <= 1'b1;
    end
    else
    begin
      cnt_r  <= cnt_r + 12'h001;
      tick_r <= 1'b0;
    end
  end

  assign tick = tick_r;

  a_tick_gap: assert property (@(posedge pclk) disable iff (!presetn)
    tick_r |=> !tick_r) // R16
    else $error("tick pulses back to back");
endmodule

// file: tb/fdbs_stage_model.sv
// Model of the power stage, breaker switches and host fault line
`timescale 1ns/1ns
module fdbs_stage_model (
  // Clock
  input  wire logic       pclk,
  // From the sequencer
  input  wire logic       detect_active,
  input  wire logic       breaker_source_on,
  input  wire logic       fault_flag_n_oe,
  // Scenario controls
  input  wire logic       host_pull,
  input  wire logic       shorted,
  input  wire logic [7:0] gate_dly,
  // Back to the sequencer
  output logic            fault_flag_n_in,
  output logic            short_found,
  output logic            breaker_gate_good
);
  logic [7:0] gate_cnt_r;

  // Open-drain flag with pull-up; host may pull it low too
  assign fault_flag_n_in = ~(fault_flag_n_oe | host_pull);

  // Short only visible while the check runs
  assign short_found = detect_active & shorted;

  // Gate charges slowly; gate_dly sets a prompt or slow breaker
  always_ff @(posedge pclk)
  begin
    if (!breaker_source_on)
      gate_cnt_r <= 8'h00;
    else if (gate_cnt_r != 8'hff)
      gate_cnt_r <= gate_cnt_r + 8'h01;
  end

  // Good only with the source on and the gate charged
  assign breaker_gate_good = breaker_source_on & (gate_cnt_r >= gate_dly);
endmodule

// file: tb/tb_fdbs_seq.sv
// Self-checking bench for the start-up and fault sequencer
`timescale 1ns/1ns
`include "fdbs_consts.svh"
module tb_fdbs_seq;
  import fdbs_pkg::*;
  // Shortened counts keep the run brief
  localparam int TICK = 2;
  localparam int STBY = 5;
  localparam int DET  = 8;
  localparam logic [7:0] A_CTL = `FDBS_CTRL_OFS;
  localparam logic [7:0] A_ST  = `FDBS_STAT_OFS;
  localparam logic [7:0] A_IS  = `FDBS_ISTAT_OFS;
  localparam logic [7:0] A_IM  = `FDBS_IMASK_OFS;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr, gate_dly;
  logic [31:0] pwdata, prdata, rd;
  logic        bias_ok, bias_lost, uv_enable_on, uv_enable_off;
  logic        clock_chain_output_term, short_found, breaker_gate_good;
  logic        hv_overvoltage_sense, lv_overvoltage_sense, boost_mode;
  logic        channel_one_enable, channel_two_enable, fault_flag_n_in;
  logic        fault_flag_n_out, fault_flag_n_oe, breaker_source_on;
  logic        detect_active, ss_discharge, standby, irq, host_pull, shorted;
  logic [1:0]  high_side_drive, low_side_drive;
  fdbs_state_t seq_state;
  int          mismatches, compares, n;

  fdbs_seq #(.TICK_CYC(TICK), .STBY_TICKS(STBY), .DET_TICKS(DET))
  i_fdbs_seq (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .bias_ok, .bias_lost, .uv_enable_on, .uv_enable_off,
    .clock_chain_output_term, .short_found, .breaker_gate_good,
    .hv_overvoltage_sense, .lv_overvoltage_sense, .boost_mode,
    .channel_one_enable, .channel_two_enable, .fault_flag_n_in,
    .fault_flag_n_out, .fault_flag_n_oe, .breaker_source_on, .detect_active,
    .high_side_drive, .low_side_drive, .ss_discharge, .standby, .seq_state,
    .irq
  );

  fdbs_stage_model i_fdbs_stage_model (
    .pclk, .detect_active, .breaker_source_on, .fault_flag_n_oe, .host_pull,
    .shorted, .gate_dly, .fault_flag_n_in, .short_found, .breaker_gate_good
  );

  // 100 MHz clock
  always #5 pclk = ~pclk;

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Verdict and end of run
  task automatic summarize;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // A bounded wait ran out
  task automatic tmo(input string nm);
    mismatches++;
    $display("ERROR %s expected done seen timeout", nm);
    summarize();
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask

  // One APB transfer; read data and error land in rd and err
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1)
      tmo("pready");
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Wait for a state; n counts the edges taken
  task automatic wait_for(input fdbs_state_t s, input int lim);
    n = 0;
    while (seq_state !== s && n < lim)
    begin
      @(posedge pclk);
      n++;
    end
    if (seq_state !== s)
      tmo("seq_state");
  endtask

  initial
  begin
    {pclk, presetn, psel, penable, pwrite, bias_ok, bias_lost} = 7'h00;
    {uv_enable_on, uv_enable_off, hv_overvoltage_sense} = 3'h0;
    {lv_overvoltage_sense, boost_mode, host_pull, shorted} = 4'h0;
    {channel_one_enable, channel_two_enable} = 2'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    clock_chain_output_term = 1'b1;
    gate_dly = 8'hc8;
    mismatches = 0;
    compares = 0;
    cyc(10);
    presetn <= 1'b1;
    chk("state", 32'(FDBS_IDLE), 32'(seq_state));
    chk("brk", 32'h0, 32'(breaker_source_on));
    chk("flag_oe", 32'h0, 32'(fault_flag_n_oe));
    chk("ss", 32'h1, 32'(ss_discharge));
    apb(1'b0, A_CTL, 32'h0);
    chk("ctrl", 32'h1, rd);
    apb(1'b0, A_IM, 32'h0);
    chk("imask", 32'h0, rd);
    $display("test reset done");

    // Strap fitted: skip the check, slow gate never seen good
    bias_ok <= 1'b1;
    uv_enable_on <= 1'b1;
    wait_for(FDBS_SKIP, 5);
    chk("brk", 32'h1, 32'(breaker_source_on));
    wait_for(FDBS_STANDBY, 40);
    chk("skip_len", 32'h1, 32'(n >= 8 && n <= STBY * TICK + 4));
    chk("standby", 32'h1, 32'(standby));
    chk("gate", 32'h0, 32'(breaker_gate_good));
    apb(1'b0, A_ST, 32'h0);
    chk("status", 32'h44, rd);
    apb(1'b0, A_IS, 32'h0);
    chk("istat", 32'h10, rd);
    apb(1'b1, A_IM, 32'h10);
    cyc(2);
    chk("irq", 32'h1, 32'(irq));
    apb(1'b1, A_IS, 32'h10);
    cyc(2);
    chk("irq", 32'h0, 32'(irq));
    channel_one_enable <= 1'b1;
    channel_two_enable <= 1'b1;
    cyc(3);
    chk("hs", 32'h3, 32'(high_side_drive));
    chk("ls", 32'h3, 32'(low_side_drive));
    apb(1'b1, A_CTL, 32'h0);
    cyc(3);
    chk("hs", 32'h0, 32'(high_side_drive));
    apb(1'b1, A_CTL, 32'h1);
    apb(1'b0, 8'h10, 32'h0);
    chk("slverr", 32'h1, 32'(err));
    chk("rdata", 32'h0, rd);
    cyc(3);
    $display("test skip done");

    // High port trips in boost; short trip filtered out
    boost_mode <= 1'b1;
    hv_overvoltage_sense <= 1'b1;
    cyc(300);
    chk("hs", 32'h3, 32'(high_side_drive));
    hv_overvoltage_sense <= 1'b0;
    cyc(20);
    hv_overvoltage_sense <= 1'b1;
    cyc(480);
    chk("hs", 32'h3, 32'(high_side_drive));
    cyc(40);
    chk("hs", 32'h0, 32'(high_side_drive));
    chk("ls", 32'h0, 32'(low_side_drive));
    chk("ss", 32'h1, 32'(ss_discharge));
    hv_overvoltage_sense <= 1'b0;
    cyc(520);
    chk("hs", 32'h3, 32'(high_side_drive));
    chk("ss", 32'h0, 32'(ss_discharge));
    // Low port ignored in boost, acts in buck
    lv_overvoltage_sense <= 1'b1;
    cyc(520);
    chk("hs", 32'h3, 32'(high_side_drive));
    boost_mode <= 1'b0;
    cyc(5);
    chk("hs", 32'h0, 32'(high_side_drive));
    chk("ss", 32'h1, 32'(ss_discharge));
    lv_overvoltage_sense <= 1'b0;
    cyc(520);
    chk("hs", 32'h3, 32'(high_side_drive));
    apb(1'b0, A_IS, 32'h0);
    chk("istat", 32'h0c, rd);
    apb(1'b1, A_IS, 32'h1f);
    $display("test overvoltage done");

    // Flag glitch ignored, long pull latches shutdown
    host_pull <= 1'b1;
    cyc(150);
    host_pull <= 1'b0;
    cyc(5);
    chk("state", 32'(FDBS_STANDBY), 32'(seq_state));
    host_pull <= 1'b1;
    wait_for(FDBS_FAULT, 260);
    chk("flt_len", 32'h1, 32'(n >= 195));
    chk("brk", 32'h0, 32'(breaker_source_on));
    chk("hs", 32'h0, 32'(high_side_drive));
    chk("standby", 32'h0, 32'(standby));
    host_pull <= 1'b0;
    cyc(300);
    chk("state", 32'(FDBS_FAULT), 32'(seq_state));
    chk("flag", 32'h0, 32'(fault_flag_n_in));
    apb(1'b0, A_IS, 32'h0);
    chk("istat", 32'h02, rd);
    uv_enable_off <= 1'b1;
    uv_enable_on <= 1'b0;
    wait_for(FDBS_IDLE, 5);
    chk("flag_oe", 32'h0, 32'(fault_flag_n_oe));
    $display("test fault flag done");

    // Detection on with a shorted switch
    uv_enable_off <= 1'b0;
    clock_chain_output_term <= 1'b0;
    shorted <= 1'b1;
    apb(1'b1, A_IS, 32'h1f);
    cyc(20);
    chk("state", 32'(FDBS_IDLE), 32'(seq_state));
    uv_enable_on <= 1'b1;
    // Start waits until the flag filter reads released again
    wait_for(FDBS_DETECT, 250);
    chk("det", 32'h1, 32'(detect_active));
    wait_for(FDBS_FAULT, 5);
    chk("flag_oe", 32'h1, 32'(fault_flag_n_oe));
    chk("brk", 32'h0, 32'(breaker_source_on));
    chk("flag_out", 32'h0, 32'(fault_flag_n_out));
    apb(1'b0, A_ST, 32'h0);
    // Filtered flag still reads released so soon after the pull
    chk("status", 32'h4d, rd);
    apb(1'b0, A_IS, 32'h0);
    chk("ist_short", 32'h1, rd & 32'h1);
    bias_lost <= 1'b1;
    wait_for(FDBS_IDLE, 5);
    chk("flag_oe", 32'h0, 32'(fault_flag_n_oe));
    chk("ss", 32'h1, 32'(ss_discharge));
    $display("test short done");

    // Clean check, breaker charges, then standby
    bias_lost <= 1'b0;
    shorted <= 1'b0;
    gate_dly <= 8'h1e;
    wait_for(FDBS_DETECT, 5);
    wait_for(FDBS_CHARGE, 40);
    chk("det_len", 32'h1, 32'(n >= 13 && n <= DET * TICK + 3));
    cyc(2);
    chk("brk", 32'h1, 32'(breaker_source_on));
    wait_for(FDBS_STANDBY, 80);
    chk("gate_wait", 32'h1, 32'(n >= 25));
    cyc(3);
    chk("hs", 32'h3, 32'(high_side_drive));
    apb(1'b0, A_ST, 32'h0);
    chk("status", 32'h4c, rd);
    $display("test detect done");
    summarize();
  end
endmodule
